// *** rtl/bank_cmd_ctrl.sv ***
// controller end: issues one user command when legal, waits out timings
// assumes user request is from logic on mclk_in; self refresh is not used
module bank_cmd_ctrl (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic req_in,
	input wire bank_cmd_pkg::cmd_t req_cmd_in,
	input wire logic [bank_cmd_pkg::BANK_W-1:0] req_bank_in,
	input wire logic [bank_cmd_pkg::ROW_W-1:0] req_addr_in,
	output logic ack_out,
	bank_cmd_if.ctrl cmd_if
);
	import bank_cmd_pkg::*;

	bank_state_t st_reg [NUM_BANKS];
	logic [CNT_W-1:0] cnt_reg [NUM_BANKS];
	logic [CNT_W-1:0] gap_rd_reg, gap_wr_reg, gap_row_reg, global_reg;
	logic ok;
	logic ap;
	logic all_idle;
	logic pre_all_ok;
	bank_state_t s;

	assign ap = req_addr_in[ALL_BANK_SELECT_BIT];
	assign s = st_reg[req_bank_in];
	always_comb begin
		all_idle = 1'b1;
		pre_all_ok = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++) begin
			if (st_reg[i] != BS_IDLE)
				all_idle = 1'b0;
			// precharge all only when every bank may take it
			if (!(st_reg[i] inside {BS_IDLE, BS_ACTIVE}))
				pre_all_ok = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// legality of the pending request
	// ------------------------------------------------------------
	always_comb begin
		ok = 1'b0;
		if (global_reg == '0 && !ack_out) begin
			unique case (req_cmd_in)
				CMD_ACTIVATE: ok = s == BS_IDLE && gap_row_reg == '0;
				CMD_REFRESH, CMD_LOAD_MODE: ok = all_idle;
				CMD_READ: ok = (s == BS_ACTIVE || s == BS_READ) && gap_rd_reg == '0;
				CMD_WRITE: ok = s == BS_ACTIVE && gap_wr_reg == '0;
				CMD_PRECHARGE: ok = gap_row_reg == '0
					&& (ap ? pre_all_ok : s == BS_ACTIVE);
				default: ok = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// pins and shadow state
	// ------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			{cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'hF;
			cmd_if.cke <= 1'b0;
			cmd_if.bank_addr <= '0;
			cmd_if.addr <= '0;
			ack_out <= 1'b0;
		end else begin
			cmd_if.cke <= 1'b1;
			// ack only when the command really goes out on the pins
			ack_out <= req_in && ok && cmd_if.cke;
			cmd_if.bank_addr <= req_bank_in;
			cmd_if.addr <= req_addr_in;
			{cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'h7;
			if (req_in && ok && cmd_if.cke)
				unique case (req_cmd_in)
					CMD_ACTIVATE: {cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'h3;
					CMD_REFRESH: {cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'h1;
					CMD_LOAD_MODE: {cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'h0;
					CMD_READ: {cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'h5;
					CMD_WRITE: {cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'h4;
					CMD_PRECHARGE: {cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n} <= 4'h2;
					default: ;
				endcase
		end
	end

	logic go;
	assign go = req_in && ok && cmd_if.cke;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			gap_rd_reg <= '0;
			gap_wr_reg <= '0;
			gap_row_reg <= '0;
			global_reg <= '0;
		end else begin
			gap_rd_reg <= gap_rd_reg != '0 ? gap_rd_reg - CNT_W'(1) : '0;
			gap_wr_reg <= gap_wr_reg != '0 ? gap_wr_reg - CNT_W'(1) : '0;
			gap_row_reg <= gap_row_reg != '0 ? gap_row_reg - CNT_W'(1) : '0;
			global_reg <= global_reg != '0 ? global_reg - CNT_W'(1) : '0;
			if (go && req_cmd_in == CMD_WRITE && ap) begin
				gap_rd_reg <= CNT_W'(WAP_TO_READ);
				gap_wr_reg <= CNT_W'(WAP_TO_WRITE);
				gap_row_reg <= CNT_W'(AP_TO_ROWCMD);
			end else if (go && req_cmd_in == CMD_READ && ap) begin
				gap_rd_reg <= CNT_W'(RAP_TO_READ);
				gap_wr_reg <= CNT_W'(RAP_TO_WRITE);
				gap_row_reg <= CNT_W'(AP_TO_ROWCMD);
			end
			if (go && req_cmd_in == CMD_REFRESH)
				global_reg <= CNT_W'(REFRESH_CYC + 1);
			else if (go && req_cmd_in == CMD_LOAD_MODE)
				global_reg <= CNT_W'(MODE_CYC + 1);
			else if (go && req_cmd_in == CMD_PRECHARGE && ap)
				global_reg <= CNT_W'(PRECHARGE_CYC + 1);
		end
	end

	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_shadow
			logic hit;
			assign hit = req_bank_in == BANK_W'(b);
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					st_reg[b] <= BS_IDLE;
					cnt_reg[b] <= '0;
				end else if (go && req_cmd_in == CMD_PRECHARGE && ap) begin
					st_reg[b] <= BS_PRECHARGING;
					cnt_reg[b] <= CNT_W'(PRECHARGE_CYC + 1);
				end else if (go && hit && req_cmd_in inside {CMD_ACTIVATE, CMD_READ,
					CMD_WRITE, CMD_PRECHARGE}) begin
					unique case (req_cmd_in)
						CMD_ACTIVATE: begin
							st_reg[b] <= BS_ACTIVATING;
							cnt_reg[b] <= CNT_W'(ACT_CYC + 1);
						end
						CMD_READ: begin
							st_reg[b] <= ap ? BS_READ_AP : BS_READ;
							cnt_reg[b] <= ap ? CNT_W'(RD_BURST_CYC + PRECHARGE_CYC + 1)
								: CNT_W'(RD_BURST_CYC + 1);
						end
						CMD_WRITE: begin
							st_reg[b] <= ap ? BS_WRITE_AP : BS_WRITE;
							cnt_reg[b] <= ap ?
								CNT_W'(WR_BURST_CYC + WR_RECOVERY_CYC + PRECHARGE_CYC + 1)
								: CNT_W'(WR_BURST_CYC + WR_RECOVERY_CYC + 1);
						end
						default: begin
							st_reg[b] <= BS_PRECHARGING;
							cnt_reg[b] <= CNT_W'(PRECHARGE_CYC + 1);
						end
					endcase
				end else if (cnt_reg[b] > CNT_W'(1)) begin
					cnt_reg[b] <= cnt_reg[b] - CNT_W'(1);
				end else if (cnt_reg[b] == CNT_W'(1)) begin
					cnt_reg[b] <= '0;
					st_reg[b] <= st_reg[b] inside {BS_ACTIVATING, BS_READ, BS_WRITE}
						? BS_ACTIVE : BS_IDLE;
				end
			end
		end
	endgenerate
endmodule : bank_cmd_ctrl

// *** rtl/bank_cmd_device.sv ***
// memory end: decodes strobes and tracks per-bank state and timing
// assumes command pins come from logic on mclk_in
module bank_cmd_device #(
	parameter int NB = bank_cmd_pkg::NUM_BANKS
) (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	bank_cmd_if.mem cmd_if,
	output logic [NB-1:0] bank_idle_out,
	output logic [NB-1:0] bank_active_out,
	output logic all_idle_out,
	output logic term_disable_out,
	output logic illegal_cmd_out
);
	import bank_cmd_pkg::*;

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	function automatic cmd_t decode(input logic cs_n, input logic ras_n,
		input logic cas_n, input logic we_n);
		cmd_t c;
		c = CMD_NOP;
		if (ras_n && !cas_n && we_n && cs_n)
			c = CMD_TERM_DISABLE;
		else if (cs_n)
			c = CMD_DESELECT;
		else
			unique case ({ras_n, cas_n, we_n})
				3'b111: c = CMD_NOP;
				3'b011: c = CMD_ACTIVATE;
				3'b001: c = CMD_REFRESH;
				3'b000: c = CMD_LOAD_MODE;
				3'b101: c = CMD_READ;
				3'b100: c = CMD_WRITE;
				3'b010: c = CMD_PRECHARGE;
				// unlisted pattern, no action
				3'b110: c = CMD_NOP;
			endcase
		return c;
	endfunction : decode

	cmd_t cmd;
	logic cke_prev_reg;
	logic valid_edge;
	logic ap;
	logic all_sel;
	logic [NB-1:0] idle_vec;
	bank_state_t state_reg [NB];
	logic [CNT_W-1:0] cnt_reg [NB];

	assign cmd = decode(cmd_if.cs_n, cmd_if.ras_n, cmd_if.cas_n, cmd_if.we_n);
	assign ap = cmd_if.addr[ALL_BANK_SELECT_BIT];
	assign all_sel = cmd_if.addr[ALL_BANK_SELECT_BIT];
	assign valid_edge = cke_prev_reg && cmd_if.cke;

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			cke_prev_reg <= 1'b0;
		else
			cke_prev_reg <= cmd_if.cke;
	end

	// ------------------------------------------------------------
	// per-bank state machines
	// ------------------------------------------------------------
	genvar b;
	generate
		for (b = 0; b < NB; b++) begin : g_bank
			logic hit;
			assign hit = cmd_if.bank_addr == BANK_W'(b);
			assign idle_vec[b] = state_reg[b] == BS_IDLE;
			always_ff @(posedge mclk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					state_reg[b] <= BS_IDLE;
					cnt_reg[b] <= '0;
				end else begin
					if (cnt_reg[b] != '0)
						cnt_reg[b] <= cnt_reg[b] - CNT_W'(1);
					unique case (state_reg[b])
						BS_IDLE: begin
							if (valid_edge && cmd == CMD_ACTIVATE && hit) begin
								state_reg[b] <= BS_ACTIVATING;
								cnt_reg[b] <= CNT_W'(ACT_CYC - 1);
							end else if (valid_edge && cmd == CMD_REFRESH && &idle_vec) begin
								state_reg[b] <= BS_REFRESH;
								cnt_reg[b] <= CNT_W'(REFRESH_CYC - 1);
							end else if (valid_edge && cmd == CMD_LOAD_MODE && &idle_vec) begin
								state_reg[b] <= BS_MODE;
								cnt_reg[b] <= CNT_W'(MODE_CYC - 1);
							end else if (valid_edge && cmd == CMD_PRECHARGE && all_sel) begin
								state_reg[b] <= BS_PRE_ALL;
								cnt_reg[b] <= CNT_W'(PRECHARGE_CYC - 1);
							end
						end
						BS_ACTIVATING, BS_PRECHARGING: begin
							if (cnt_reg[b] == '0)
								state_reg[b] <= state_reg[b] == BS_ACTIVATING ? BS_ACTIVE : BS_IDLE;
						end
						BS_REFRESH, BS_MODE, BS_PRE_ALL: begin
							if (cnt_reg[b] == '0)
								state_reg[b] <= BS_IDLE;
						end
						BS_READ_AP, BS_WRITE_AP: begin
							if (cnt_reg[b] == '0)
								state_reg[b] <= BS_IDLE;
						end
						BS_ACTIVE, BS_READ, BS_WRITE: begin
							if (state_reg[b] != BS_ACTIVE && cnt_reg[b] == '0)
								state_reg[b] <= BS_ACTIVE;
							if (valid_edge && cmd == CMD_READ && hit) begin
								state_reg[b] <= ap ? BS_READ_AP : BS_READ;
								// read: burst, plus precharge time with auto precharge
								cnt_reg[b] <= ap ? CNT_W'(RD_BURST_CYC + PRECHARGE_CYC - 1)
									: CNT_W'(RD_BURST_CYC - 1);
							end else if (valid_edge && cmd == CMD_WRITE && hit) begin
								state_reg[b] <= ap ? BS_WRITE_AP : BS_WRITE;
								// write: burst, plus recovery and precharge time with auto precharge
								cnt_reg[b] <= ap ?
									CNT_W'(WR_BURST_CYC + WR_RECOVERY_CYC + PRECHARGE_CYC - 1)
									: CNT_W'(WR_BURST_CYC - 1);
							end else if (valid_edge && cmd == CMD_PRECHARGE
								&& (hit || all_sel)) begin
								state_reg[b] <= all_sel ? BS_PRE_ALL : BS_PRECHARGING;
								cnt_reg[b] <= CNT_W'(PRECHARGE_CYC - 1);
							end
						end
					endcase
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// status outputs
	// ------------------------------------------------------------
	logic illegal;
	always_comb begin
		illegal = 1'b0;
		if (valid_edge) begin
			unique case (cmd)
				CMD_REFRESH, CMD_LOAD_MODE: illegal = !(&idle_vec);
				CMD_ACTIVATE: illegal = state_reg[cmd_if.bank_addr] != BS_IDLE;
				CMD_READ, CMD_WRITE: illegal = !(state_reg[cmd_if.bank_addr] inside
					{BS_ACTIVE, BS_READ, BS_WRITE});
				CMD_PRECHARGE: illegal = !all_sel && !(state_reg[cmd_if.bank_addr] inside
					{BS_ACTIVE, BS_IDLE});
				default: illegal = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			bank_idle_out <= '1;
			bank_active_out <= '0;
			all_idle_out <= 1'b1;
			term_disable_out <= 1'b0;
			illegal_cmd_out <= 1'b0;
		end else begin
			for (int i = 0; i < NB; i++) begin
				bank_idle_out[i] <= state_reg[i] == BS_IDLE;
				bank_active_out[i] <= state_reg[i] == BS_ACTIVE;
			end
			all_idle_out <= &idle_vec;
			term_disable_out <= cmd == CMD_TERM_DISABLE;
			illegal_cmd_out <= illegal;
		end
	end
endmodule : bank_cmd_device

// *** rtl/bank_cmd_if.sv ***
// interface joining controller and memory command pins
// assumes both ends on the same clock; pins are plain single-direction wires
interface bank_cmd_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	logic [bank_cmd_pkg::BANK_W-1:0] bank_addr;
	logic [bank_cmd_pkg::ROW_W-1:0] addr;
	modport ctrl (output cs_n, ras_n, cas_n, we_n, cke, bank_addr, addr);
	modport mem (input cs_n, ras_n, cas_n, we_n, cke, bank_addr, addr);
endinterface : bank_cmd_if

// *** rtl/bank_cmd_pkg.sv ***
// package of command codes, bank states and timing counts for the sdram bank command link
// assumes a single clock at 25 MHz shared by both ends
package bank_cmd_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int NUM_BANKS = 4;
	localparam int BANK_W = 2;
	localparam int ROW_W = 12;
	localparam int ALL_BANK_SELECT_BIT = 8;
	// timings in ns as figures of the part, counts rounded up to whole cycles
	localparam int PRECHARGE_TIME_NS = 120;
	localparam int ACTIVATE_TO_ACCESS_TIME_NS = 120;
	localparam int REFRESH_CYCLE_TIME_NS = 400;
	localparam int MODE_LOAD_DELAY_NS = 80;
	localparam int WRITE_RECOVERY_TIME_NS = 160;
	localparam int WRITE_TO_READ_DELAY_NS = 40;
	localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACT_CYC = (ACTIVATE_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MODE_CYC = (MODE_LOAD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_RECOVERY_CYC = (WRITE_RECOVERY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_TO_RD_CYC = (WRITE_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_LATENCY_CLOCKS = 3;
	localparam int BURST_LENGTH_WORDS = 4;
	localparam int ROUNDED_READ_LATENCY = 5;
	localparam int HALF_BURST = BURST_LENGTH_WORDS / 2;
	// gaps after an auto precharge access to another bank
	localparam int WAP_TO_READ = WRITE_LATENCY_CLOCKS + HALF_BURST + WR_TO_RD_CYC;
	localparam int WAP_TO_WRITE = HALF_BURST;
	localparam int RAP_TO_READ = HALF_BURST;
	localparam int RAP_TO_WRITE = ROUNDED_READ_LATENCY + HALF_BURST + 1 - WRITE_LATENCY_CLOCKS;
	localparam int AP_TO_ROWCMD = 1;
	// write burst ends wl + half burst after command
	localparam int WR_BURST_CYC = WRITE_LATENCY_CLOCKS + HALF_BURST;
	localparam int RD_BURST_CYC = HALF_BURST;
	localparam int CNT_W = 6;

	typedef enum logic [3:0] {
		CMD_DESELECT, CMD_NOP, CMD_TERM_DISABLE, CMD_ACTIVATE, CMD_REFRESH,
		CMD_LOAD_MODE, CMD_READ, CMD_WRITE, CMD_PRECHARGE
	} cmd_t;

	typedef enum logic [3:0] {
		BS_IDLE, BS_ACTIVATING, BS_ACTIVE, BS_READ, BS_WRITE, BS_READ_AP,
		BS_WRITE_AP, BS_PRECHARGING, BS_REFRESH, BS_MODE, BS_PRE_ALL
	} bank_state_t;
endpackage : bank_cmd_pkg

// *** test/bank_cmd_props.sv ***
// checker on the command pins shared by controller and memory end
// assumes pins change only just after rising edges of mclk_in
module bank_cmd_props (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic cke,
	input wire logic [bank_cmd_pkg::BANK_W-1:0] bank_addr,
	input wire logic [bank_cmd_pkg::ROW_W-1:0] addr
);
	timeunit 1ns;
	timeprecision 1ns;
	import bank_cmd_pkg::*;
	logic act, rfr, mrs, rd, wr, pre, ex, nop, ab;
	logic [7:0] t_ref, t_mrs, t_pall, t_wap, t_rap;
	logic [7:0] t_act [NUM_BANKS];
	// ----------------
	// decode, cycles since refresh, mode load, each bank's activate and each auto or all-bank command
	// ----------------
	assign act = !cs_n && !ras_n && cas_n && we_n;
	assign rfr = !cs_n && !ras_n && !cas_n && we_n;
	assign mrs = !cs_n && !ras_n && !cas_n && !we_n;
	assign rd = !cs_n && ras_n && !cas_n && we_n;
	assign wr = !cs_n && ras_n && !cas_n && !we_n;
	assign pre = !cs_n && !ras_n && cas_n && !we_n;
	assign nop = !cs_n && ras_n && cas_n && we_n;
	assign ex = act || rfr || mrs || rd || wr || pre;
	assign ab = addr[ALL_BANK_SELECT_BIT];
	function automatic logic [7:0] step(input logic hit, input logic [7:0] t);
		return hit ? 8'h00 : (t == 8'hFF) ? t : t + 8'h01;
	endfunction : step
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			t_ref <= 8'hFF;
			t_mrs <= 8'hFF;
			t_pall <= 8'hFF;
			t_wap <= 8'hFF;
			t_rap <= 8'hFF;
			for (int b = 0; b < NUM_BANKS; b++) begin
				t_act[b] <= 8'hFF;
			end
		end else begin
			t_ref <= step(rfr, t_ref);
			t_mrs <= step(mrs, t_mrs);
			t_pall <= step(pre && ab, t_pall);
			t_wap <= step(wr && ab, t_wap);
			t_rap <= step(rd && ab, t_rap);
			for (int b = 0; b < NUM_BANKS; b++) begin
				t_act[b] <= step(act && bank_addr == BANK_W'(b), t_act[b]);
			end
		end
	end
	// ----------------
	// assertions
	// ----------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!arst_n_in);
	cke_pair_a: assert property (ex |-> cke && $past(cke))
		else $error("command without clock enable on two edges");
	cke_first_a: assert property ($rose(cke) |-> !ex)
		else $error("command on first clock enable edge");
	cmd_nop_a: assert property (ex |=> nop)
		else $error("command not followed by no-operation");
	ref_quiet_a: assert property (ex |-> t_ref >= 8'(REFRESH_CYC - 1))
		else $error("command inside refresh cycle time");
	mode_quiet_a: assert property (ex |-> t_mrs >= 8'(MODE_CYC - 1))
		else $error("command inside mode load delay");
	pall_quiet_a: assert property (ex |-> t_pall >= 8'(PRECHARGE_CYC - 1))
		else $error("command inside precharge-all time");
	act_wait_a: assert property ((rd || wr || (pre && !ab))
		|-> t_act[bank_addr] >= 8'(ACT_CYC - 1))
		else $error("access to a bank still activating");
	wap_gap_a: assert property (rd |-> t_wap >= 8'(WAP_TO_READ - 1))
		else $error("read too soon after write with auto precharge");
	rap_gap_a: assert property (wr |-> t_rap >= 8'(RAP_TO_WRITE - 1))
		else $error("write too soon after read with auto precharge");
	ref_c: cover property (rfr);
	mode_c: cover property (mrs);
	wap_c: cover property (wr && ab);
	pall_c: cover property (pre && ab);
endmodule : bank_cmd_props

// *** test/sdram_bank_command_rules_tb.sv ***
// bench: controller facing memory end, plus a memory end on bench-driven pins
// assumes package, interface and both ends compiled first
module sdram_bank_command_rules_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import bank_cmd_pkg::*;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic req_in = 1'b0;
	cmd_t req_cmd_in = CMD_NOP;
	logic [BANK_W-1:0] req_bank_in = '0;
	logic [ROW_W-1:0] req_addr_in = '0;
	logic ack_out, all_idle, term, ill, r_all_idle, r_term, r_ill, saw_ill, saw_term;
	logic [NUM_BANKS-1:0] idle, active, r_idle, r_active;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;
	logic ctrl_bad = 1'b0;
	// ----------------
	// instances
	// ----------------
	bank_cmd_if i_bank_cmd_if ();
	bank_cmd_if i_raw_if ();
	bank_cmd_ctrl i_bank_cmd_ctrl (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.req_in(req_in), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
		.req_addr_in(req_addr_in), .ack_out(ack_out), .cmd_if(i_bank_cmd_if.ctrl));
	bank_cmd_device i_bank_cmd_device (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.cmd_if(i_bank_cmd_if.mem), .bank_idle_out(idle), .bank_active_out(active),
		.all_idle_out(all_idle), .term_disable_out(term), .illegal_cmd_out(ill));
	bank_cmd_device i_bank_cmd_device_b (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.cmd_if(i_raw_if.mem), .bank_idle_out(r_idle), .bank_active_out(r_active),
		.all_idle_out(r_all_idle), .term_disable_out(r_term), .illegal_cmd_out(r_ill));
	bank_cmd_props i_bank_cmd_props (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.cs_n(i_bank_cmd_if.cs_n), .ras_n(i_bank_cmd_if.ras_n), .cas_n(i_bank_cmd_if.cas_n),
		.we_n(i_bank_cmd_if.we_n), .cke(i_bank_cmd_if.cke),
		.bank_addr(i_bank_cmd_if.bank_addr), .addr(i_bank_cmd_if.addr));
	initial begin
		forever #20 mclk_in = ~mclk_in;
	end
	// ----------------
	// tasks
	// ----------------
	task automatic close_out();
		if (failures == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	always @(posedge mclk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures = failures + 1;
			close_out();
		end
	end
	// sticky: memory end flagged the controller's traffic
	always @(posedge mclk_in) begin
		if (arst_n_in && (ill !== 1'b0 || term !== 1'b0))
			ctrl_bad <= 1'b1;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask : tick
	// user request held until ack or until the wait runs out
	task automatic issue(input cmd_t c, input logic [1:0] b, input logic a8, input logic exp);
		@(posedge mclk_in);
		req_in <= 1'b1;
		req_cmd_in <= c;
		req_bank_in <= b;
		req_addr_in <= {3'h0, a8, 8'h00};
		for (int k = 0; k < 40; k++) begin
			tick(1);
			if (ack_out === 1'b1) break;
		end
		check("ack", {7'h0, ack_out}, {7'h0, exp});
		@(posedge mclk_in);
		req_in <= 1'b0;
		#1;
	endtask : issue
	// one strobe pattern {cs,ras,cas,we} to bank 0, then no-operation
	task automatic raw(input logic [3:0] p);
		@(posedge mclk_in);
		{i_raw_if.cs_n, i_raw_if.ras_n, i_raw_if.cas_n, i_raw_if.we_n} <= p;
		@(posedge mclk_in);
		{i_raw_if.cs_n, i_raw_if.ras_n, i_raw_if.cas_n, i_raw_if.we_n} <= 4'h7;
		#1;
		saw_ill = r_ill;
		saw_term = r_term;
		repeat (5) begin
			tick(1);
			saw_ill |= r_ill;
			saw_term |= r_term;
		end
	endtask : raw
	// ----------------
	// scenarios
	// ----------------
	task automatic t_decode();
		logic [3:0] p [10] = '{4'hB, 4'hD, 4'h7, 4'h5, 4'h3, 4'h1, 4'h5, 4'h2, 4'h0, 4'h1};
		logic [2:0] e [10] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h4, 3'h6, 3'h4, 3'h0, 3'h0, 3'h0};
		for (int i = 0; i < 10; i++) begin
			raw(p[i]);
			check("decode", {5'h0, r_active[0], saw_ill, saw_term}, {5'h0, e[i]});
		end
		tick(REFRESH_CYC + 2);
		check("raw idle", {3'h0, r_all_idle, r_idle}, 8'h1F);
	endtask : t_decode
	task automatic t_banks();
		issue(CMD_READ, 2'h3, 1'b0, 1'b0);
		for (int b = 0; b < 3; b++) begin
			issue(CMD_ACTIVATE, 2'(b), 1'b0, 1'b1);
		end
		tick(ACT_CYC + 2);
		check("idle", {active, idle}, 8'h78);
		issue(CMD_REFRESH, 2'h0, 1'b0, 1'b0);
		issue(CMD_WRITE, 2'h2, 1'b1, 1'b1);
		issue(CMD_READ, 2'h1, 1'b0, 1'b1);
		check("ap busy", {4'h0, idle}, 8'h08);
		issue(CMD_READ, 2'h1, 1'b1, 1'b1);
		issue(CMD_WRITE, 2'h0, 1'b0, 1'b1);
		tick(20);
		check("ap done", {active, idle}, 8'h1E);
		issue(CMD_PRECHARGE, 2'h0, 1'b0, 1'b1);
		tick(PRECHARGE_CYC + 2);
		check("pre one", {4'h0, idle}, 8'h0F);
		issue(CMD_ACTIVATE, 2'h0, 1'b0, 1'b1);
		issue(CMD_ACTIVATE, 2'h3, 1'b0, 1'b1);
		tick(ACT_CYC + 2);
		issue(CMD_PRECHARGE, 2'h1, 1'b1, 1'b1);
		tick(2);
		check("pre all busy", {7'h0, all_idle}, 8'h00);
		tick(PRECHARGE_CYC + 2);
		check("pre all", {3'h0, all_idle, idle}, 8'h1F);
	endtask : t_banks
	task automatic t_quiet();
		cmd_t c [2] = '{CMD_REFRESH, CMD_LOAD_MODE};
		int w [2] = '{REFRESH_CYC, MODE_CYC};
		for (int i = 0; i < 2; i++) begin
			issue(c[i], 2'h0, 1'b0, 1'b1);
			tick(2);
			check("busy", {7'h0, all_idle}, 8'h00);
			tick(w[i] + 2);
			check("back idle", {3'h0, all_idle, idle}, 8'h1F);
		end
		tick(2);
		check("ctrl legal", {7'h0, ctrl_bad}, 8'h00);
	endtask : t_quiet
	initial begin
		{i_raw_if.cs_n, i_raw_if.ras_n, i_raw_if.cas_n, i_raw_if.we_n} = 4'hF;
		i_raw_if.cke = 1'b1;
		i_raw_if.bank_addr = '0;
		i_raw_if.addr = '0;
		repeat (3) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		tick(3);
		check("reset", {3'h0, all_idle, idle}, 8'h1F);
		check("reset act", {active, r_active}, 8'h00);
		t_decode();
		t_banks();
		t_quiet();
		close_out();
	end
endmodule : sdram_bank_command_rules_tb
